/* wts_regs.svh */
`ifndef WTS_REGS_SVH
`define WTS_REGS_SVH
// ==========================================================
// Register offsets (byte addresses, one 16-bit word each)
`define WTS_OFS_CTRL     8'h00
`define WTS_OFS_BLANK    8'h04
`define WTS_OFS_CONFIRM  8'h08
`define WTS_OFS_BRKLVL   8'h0c
`define WTS_OFS_DEVLVL   8'h10
`define WTS_OFS_HALT     8'h14
`define WTS_OFS_INCHSPD  8'h18
`define WTS_OFS_INCHACC  8'h1c
`define WTS_OFS_INCHDEC  8'h20
`define WTS_OFS_SPLICE   8'h24
`define WTS_OFS_TOPSPD   8'h28
`define WTS_OFS_ASSIGN   8'h2c
`define WTS_OFS_STATUS   8'h30
`define WTS_OFS_IRQST    8'h34
`define WTS_OFS_IRQMASK  8'h38
// ==========================================================
// Field positions
`define WTS_CTRL_BRKEN   0
`define WTS_CTRL_DEVEN   1
`define WTS_CTRL_RAMPSEL 2
// ==========================================================
// Reset values (times in 0.1 s or 0.01 s, levels in 0.1 %)
`define WTS_RST_CTRL     3'h4
`define WTS_RST_BLANK    16'h000a
`define WTS_RST_CONFIRM  16'h000a
`define WTS_RST_BRKLVL   16'h0000
`define WTS_RST_DEVLVL   16'h0000
`define WTS_RST_HALT     16'h000a
`define WTS_RST_INCHSPD  16'h0064
`define WTS_RST_INCHACC  16'h01f4
`define WTS_RST_INCHDEC  16'h01f4
`define WTS_RST_SPLICE   16'h0000
`define WTS_RST_TOPSPD   16'h0708
`define WTS_RST_ASSIGN   4'h0
// ==========================================================
// Timing and scaling
`define WTS_CLK_NS       100
`define WTS_TICK_US      1000
`define WTS_TICK_CYCLES  (`WTS_TICK_US * 1000 / `WTS_CLK_NS)
`define WTS_TENTH_MS     100
`define WTS_TENTH_TICKS  (`WTS_TENTH_MS * 1000 / `WTS_TICK_US)
`define WTS_FULL_SCALE   1000
`define WTS_DEV_BAND     16'h0014
`endif

/* wts_pkg.sv */
`include "wts_regs.svh"
package wts_pkg;
   // ==========================================================
   // Drive supervision states
   typedef enum logic [3:0] {
      WTS_STOP  = 4'h1,
      WTS_BLANK = 4'h2,
      WTS_RUN   = 4'h4,
      WTS_HALT  = 4'h8
   } wts_state_t;

   // Contact output functions
   typedef enum logic [1:0] {
      WTS_FN_NONE  = 2'h0,
      WTS_FN_BREAK = 2'h1,
      WTS_FN_DEV   = 2'h2,
      WTS_FN_HALT  = 2'h3
   } wts_fn_t;

   // ==========================================================
   // Setting registers
   typedef struct packed {
      logic [2:0]  ctrl;
      logic [15:0] blank;
      logic [15:0] confirm;
      logic [15:0] brkLvl;
      logic [15:0] devLvl;
      logic [15:0] haltTime;
      logic [15:0] inchSpd;
      logic [15:0] inchAcc;
      logic [15:0] inchDec;
      logic [15:0] splice;
      logic [15:0] topSpd;
      wts_fn_t     auxFn;
      wts_fn_t     ocFn;
      logic [2:0]  irqSt;
      logic [2:0]  irqMask;
   } wts_cfg_t;

   // ==========================================================
   // Whole module state
   typedef struct packed {
      wts_cfg_t    cfg;
      wts_state_t  st;
      logic [3:0]  s1;
      logic [3:0]  s2;
      logic [13:0] tickCnt;
      logic [6:0]  tenthCnt;
      logic [15:0] blankCnt;
      logic [15:0] confirmCnt;
      logic        brk;
      logic        dev;
      logic [15:0] haltStart;
      logic [19:0] haltTotal;
      logic [19:0] haltLeft;
      logic [15:0] rdata;
      logic [15:0] pidOut;
      logic [15:0] finalCmd;
      logic [15:0] motorRef;
      logic [15:0] accOut;
      logic [15:0] decOut;
      logic        diamHold;
      logic        tensionHold;
      logic        aux;
      logic        oc;
   } wts_state_s_t;
endpackage

/* wts_supervisor.sv */
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "wts_regs.svh"
module wts_supervisor
   import wts_pkg::*;
#(
   parameter int TICK_CYCLES = `WTS_TICK_CYCLES
)(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        nrst,
   // Digital inputs from the line controller
   input  wire logic        runPin,
   input  wire logic        haltPin,
   input  wire logic        inchPin,
   input  wire logic        inhibitPin,
   // Process values, 0.1 % units except speeds in rpm
   input  wire logic [15:0] tensionFb,
   input  wire logic [15:0] lineCmd,
   input  wire logic [15:0] lineSpeed,
   input  wire logic [15:0] pidIn,
   input  wire logic [15:0] speedRefIn,
   input  wire logic [15:0] baseAccel,
   input  wire logic [15:0] baseDecel,
   // Register port
   input  wire logic [7:0]  regAddr,
   input  wire logic [15:0] regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [15:0] regRdata,
   // Drive outputs
   output logic      [15:0] pidOut,
   output logic      [15:0] finalLineCmd,
   output logic      [15:0] motorSpeedRef,
   output logic      [15:0] accelTime,
   output logic      [15:0] decelTime,
   output logic             diamHold,
   output logic             tensionHold,
   // Contact outputs and interrupt
   output logic             auxContact,
   output logic             ocContact,
   output logic             irq
);

   // ==========================================================
   // Decoding helpers
   function automatic logic isActive(input wts_state_t s);
      return (s == WTS_RUN) || (s == WTS_HALT);
   endfunction

   function automatic logic contactFn(input wts_fn_t f, input logic b,
                                      input logic d, input logic h);
      case (f)
         WTS_FN_BREAK: return b;
         WTS_FN_DEV:   return d;
         WTS_FN_HALT:  return h;
         default:      return 1'b0;
      endcase
   endfunction

   wts_state_s_t cur;
   wts_state_s_t nx;

   // ==========================================================
   // Combinational helpers
   logic        runOn;
   logic        haltOn;
   logic        inchOn;
   logic        inhibitOn;
   logic        tickHit;
   logic        tenthHit;
   logic        tensionLow;
   logic [15:0] devAbs;
   logic [31:0] devProd;
   logic [31:0] setThr;
   logic [31:0] clrThr;
   logic [15:0] clrLvl;
   logic [31:0] inchProd;
   logic [35:0] haltProd;
   logic [31:0] spliceProd;
   logic        enterHalt;
   logic        haltDone;
   logic [2:0]  irqEv;
   logic [2:0]  irqClr;

   assign runOn      = cur.s2[3];
   assign haltOn     = cur.s2[2];
   assign inchOn     = cur.s2[1];
   assign inhibitOn  = cur.s2[0];
   assign tickHit    = cur.tickCnt == 14'(TICK_CYCLES - 1);
   assign tenthHit   = tickHit && (cur.tenthCnt == 7'(`WTS_TENTH_TICKS - 1));
   assign tensionLow = tensionFb < cur.cfg.brkLvl;
   assign devAbs     = (lineCmd > lineSpeed) ? (lineCmd - lineSpeed)
                                             : (lineSpeed - lineCmd);
   // Deviation compared as a fraction of the command, no divider needed
   assign devProd    = 32'(devAbs) * 32'(`WTS_FULL_SCALE);
   assign setThr     = 32'(cur.cfg.devLvl) * 32'(lineCmd);
   assign clrLvl     = (cur.cfg.devLvl > `WTS_DEV_BAND)
                       ? (cur.cfg.devLvl - `WTS_DEV_BAND) : 16'h0000;
   assign clrThr     = 32'(clrLvl) * 32'(lineCmd);
   assign inchProd   = 32'(cur.cfg.inchSpd) * 32'(cur.cfg.topSpd);
   assign haltProd   = 36'(cur.haltStart) * 36'(cur.haltLeft);
   assign spliceProd = 32'(lineCmd) * 32'(cur.cfg.splice);
   assign irqClr     = (regWr && regAddr == `WTS_OFS_IRQST) ? regWdata[2:0] : 3'h0;

   // ==========================================================
   // Next-state logic
   always_comb
   begin
      nx        = cur;
      enterHalt = 1'b0;
      haltDone  = 1'b0;
      nx.s1     = {runPin, haltPin, inchPin, inhibitPin};
      nx.s2     = cur.s1;

      // Control tick and tenth-second prescalers
      nx.tickCnt = tickHit ? 14'h0000 : cur.tickCnt + 14'h0001;
      if (tickHit)
      begin
         nx.tenthCnt = tenthHit ? 7'h00 : cur.tenthCnt + 7'h01;
      end

      // Register writes
      if (regWr)
      begin
         case (regAddr)
            `WTS_OFS_CTRL:    nx.cfg.ctrl     = regWdata[2:0];
            `WTS_OFS_BLANK:   nx.cfg.blank    = regWdata;
            `WTS_OFS_CONFIRM: nx.cfg.confirm  = regWdata;
            `WTS_OFS_BRKLVL:  nx.cfg.brkLvl   = regWdata;
            `WTS_OFS_DEVLVL:  nx.cfg.devLvl   = regWdata;
            `WTS_OFS_HALT:    nx.cfg.haltTime = regWdata;
            `WTS_OFS_INCHSPD: nx.cfg.inchSpd  = regWdata;
            `WTS_OFS_INCHACC: nx.cfg.inchAcc  = regWdata;
            `WTS_OFS_INCHDEC: nx.cfg.inchDec  = regWdata;
            `WTS_OFS_SPLICE:  nx.cfg.splice   = regWdata;
            `WTS_OFS_TOPSPD:  nx.cfg.topSpd   = regWdata;
            `WTS_OFS_ASSIGN:
            begin
               nx.cfg.auxFn = wts_fn_t'(regWdata[1:0]);
               nx.cfg.ocFn  = wts_fn_t'(regWdata[3:2]);
            end
            `WTS_OFS_IRQMASK: nx.cfg.irqMask  = regWdata[2:0];
            default:          nx.cfg.ctrl     = cur.cfg.ctrl;
         endcase
      end

      // Register reads, data valid only in the following cycle
      nx.rdata = 16'h0000;
      if (regRd)
      begin
         case (regAddr)
            `WTS_OFS_CTRL:    nx.rdata = {13'h0000, cur.cfg.ctrl};
            `WTS_OFS_BLANK:   nx.rdata = cur.cfg.blank;
            `WTS_OFS_CONFIRM: nx.rdata = cur.cfg.confirm;
            `WTS_OFS_BRKLVL:  nx.rdata = cur.cfg.brkLvl;
            `WTS_OFS_DEVLVL:  nx.rdata = cur.cfg.devLvl;
            `WTS_OFS_HALT:    nx.rdata = cur.cfg.haltTime;
            `WTS_OFS_INCHSPD: nx.rdata = cur.cfg.inchSpd;
            `WTS_OFS_INCHACC: nx.rdata = cur.cfg.inchAcc;
            `WTS_OFS_INCHDEC: nx.rdata = cur.cfg.inchDec;
            `WTS_OFS_SPLICE:  nx.rdata = cur.cfg.splice;
            `WTS_OFS_TOPSPD:  nx.rdata = cur.cfg.topSpd;
            `WTS_OFS_ASSIGN:  nx.rdata = {12'h000, cur.cfg.ocFn, cur.cfg.auxFn};
            `WTS_OFS_STATUS:  nx.rdata = {8'h00, inhibitOn, inchOn, cur.dev,
                                          cur.brk, cur.st};
            `WTS_OFS_IRQST:   nx.rdata = {13'h0000, cur.cfg.irqSt};
            `WTS_OFS_IRQMASK: nx.rdata = {13'h0000, cur.cfg.irqMask};
            default:          nx.rdata = 16'h0000;
         endcase
      end

      // Drive supervision state machine
      case (cur.st)
         WTS_STOP:
         begin
            if (runOn)
            begin
               // Restart the prescalers so the blanking time is exact
               nx.st       = WTS_BLANK;
               nx.blankCnt = cur.cfg.blank;
               nx.tickCnt  = 14'h0000;
               nx.tenthCnt = 7'h00;
            end
         end
         WTS_BLANK:
         begin
            if (!runOn)
               nx.st = WTS_STOP;
            else if (haltOn)
               enterHalt = 1'b1;
            else if (tenthHit)
            begin
               if (cur.blankCnt <= 16'h0001)
                  nx.st = WTS_RUN;
               else
                  nx.blankCnt = cur.blankCnt - 16'h0001;
            end
         end
         WTS_RUN:
         begin
            if (!runOn)
               nx.st = WTS_STOP;
            else if (haltOn)
               enterHalt = 1'b1;
         end
         WTS_HALT:
         begin
            if (!runOn)
               nx.st = WTS_STOP;
            else if (!haltOn)
               nx.st = WTS_RUN;
            else if (tickHit && cur.haltLeft != 20'h00000)
            begin
               nx.haltLeft = cur.haltLeft - 20'h00001;
               haltDone    = cur.haltLeft == 20'h00001;
            end
         end
         default: nx.st = WTS_STOP;
      endcase

      // Fixed-time halt scales the speed held at entry down to zero
      if (enterHalt)
      begin
         nx.st        = WTS_HALT;
         nx.haltStart = speedRefIn;
         nx.haltTotal = 20'(32'(cur.cfg.haltTime) * 32'(`WTS_TENTH_TICKS));
         nx.haltLeft  = nx.haltTotal;
         haltDone     = cur.cfg.haltTime == 16'h0000;
      end

      // Web break detection
      if (!cur.cfg.ctrl[`WTS_CTRL_BRKEN] || !isActive(cur.st))
      begin
         nx.brk        = 1'b0;
         nx.confirmCnt = 16'h0000;
      end
      else if (tickHit)
      begin
         if (!tensionLow)
         begin
            nx.brk        = 1'b0;
            nx.confirmCnt = 16'h0000;
         end
         else if (cur.confirmCnt >= cur.cfg.confirm)
            nx.brk = 1'b1;
         else if (tenthHit)
            nx.confirmCnt = cur.confirmCnt + 16'h0001;
      end

      // Speed deviation judgment with hysteresis band
      if (!cur.cfg.ctrl[`WTS_CTRL_DEVEN] || cur.st == WTS_STOP)
         nx.dev = 1'b0;
      else if (tickHit)
      begin
         if (devProd > setThr)
            nx.dev = 1'b1;
         else if (devProd <= clrThr)
            nx.dev = 1'b0;
      end

      // Motor speed reference, refreshed once per tick and zeroed at once on stop
      if (tickHit || nx.st == WTS_STOP)
      begin
         if (nx.st == WTS_STOP)
            nx.motorRef = 16'h0000;
         else if (cur.st == WTS_HALT)
            nx.motorRef = (cur.haltTotal == 20'h00000) ? 16'h0000
                          : 16'(haltProd / 36'(cur.haltTotal));
         else if (inchOn)
            nx.motorRef = 16'(inchProd / 32'(`WTS_FULL_SCALE));
         else
            nx.motorRef = speedRefIn;
      end

      // PID output, contacts and ramps
      nx.pidOut      = nx.brk ? 16'h0000 : pidIn;
      nx.tensionHold = nx.st == WTS_HALT;
      nx.diamHold    = inchOn;
      nx.aux         = contactFn(cur.cfg.auxFn, nx.brk, nx.dev, nx.st == WTS_HALT);
      nx.oc          = contactFn(cur.cfg.ocFn, nx.brk, nx.dev, nx.st == WTS_HALT);
      if (inchOn && cur.cfg.ctrl[`WTS_CTRL_RAMPSEL])
      begin
         nx.accOut = cur.cfg.inchAcc;
         nx.decOut = cur.cfg.inchDec;
      end
      else
      begin
         nx.accOut = baseAccel;
         nx.decOut = baseDecel;
      end

      // Splicing boost only while inhibited, out of the stop state and not inching
      if (inhibitOn && !inchOn && cur.st != WTS_STOP)
         nx.finalCmd = lineCmd + 16'(spliceProd / 32'(`WTS_FULL_SCALE));
      else
         nx.finalCmd = lineCmd;

      // Sticky events; a new event beats a simultaneous clear
      irqEv          = {haltDone, nx.dev & ~cur.dev, nx.brk & ~cur.brk};
      nx.cfg.irqSt   = (cur.cfg.irqSt & ~irqClr) | irqEv;
   end

   // ==========================================================
   // State register
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         cur              <= '0;
         cur.st           <= WTS_STOP;
         cur.cfg.ctrl     <= `WTS_RST_CTRL;
         cur.cfg.blank    <= `WTS_RST_BLANK;
         cur.cfg.confirm  <= `WTS_RST_CONFIRM;
         cur.cfg.brkLvl   <= `WTS_RST_BRKLVL;
         cur.cfg.devLvl   <= `WTS_RST_DEVLVL;
         cur.cfg.haltTime <= `WTS_RST_HALT;
         cur.cfg.inchSpd  <= `WTS_RST_INCHSPD;
         cur.cfg.inchAcc  <= `WTS_RST_INCHACC;
         cur.cfg.inchDec  <= `WTS_RST_INCHDEC;
         cur.cfg.splice   <= `WTS_RST_SPLICE;
         cur.cfg.topSpd   <= `WTS_RST_TOPSPD;
         cur.cfg.auxFn    <= WTS_FN_NONE;
         cur.cfg.ocFn     <= WTS_FN_NONE;
      end
      else
         cur <= nx;
   end

   // ==========================================================
   // Outputs
   assign regRdata      = cur.rdata;
   assign pidOut        = cur.pidOut;
   assign finalLineCmd  = cur.finalCmd;
   assign motorSpeedRef = cur.motorRef;
   assign accelTime     = cur.accOut;
   assign decelTime     = cur.decOut;
   assign diamHold      = cur.diamHold;
   assign tensionHold   = cur.tensionHold;
   assign auxContact    = cur.aux;
   assign ocContact     = cur.oc;
   assign irq           = |(cur.cfg.irqSt & cur.cfg.irqMask);

   // ==========================================================
   // Assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence s_runStart;
      cur.st == WTS_STOP ##1 cur.st == WTS_BLANK;
   endsequence

   sequence s_breakRise;
      !cur.brk ##1 cur.brk;
   endsequence

   property p_pidZero;
      cur.brk |-> pidOut == 16'h0000;
   endproperty
   a_pidZero: assert property (p_pidZero) else $error("PID output not zero in break");

   property p_contact;
      cur.cfg.auxFn == WTS_FN_BREAK && $stable(cur.cfg.auxFn) |-> auxContact == cur.brk;
   endproperty
   a_contact: assert property (p_contact) else $error("Break contact mismatch");

   property p_enable;
      !cur.cfg.ctrl[`WTS_CTRL_BRKEN] |=> !cur.brk;
   endproperty
   a_enable: assert property (p_enable) else $error("Break seen while disabled");

   property p_blank;
      (s_runStart |-> cur.blankCnt == $past(cur.cfg.blank))
         and (cur.st == WTS_BLANK |-> !cur.brk);
   endproperty
   a_blank: assert property (p_blank) else $error("Break during blanking");

   property p_level;
      s_breakRise |-> $past(tensionFb) < $past(cur.cfg.brkLvl);
   endproperty
   a_level: assert property (p_level) else $error("Break without low tension");

   property p_confirm;
      s_breakRise |-> $past(cur.confirmCnt) >= $past(cur.cfg.confirm);
   endproperty
   a_confirm: assert property (p_confirm) else $error("Break before confirm time");

   property p_devOff;
      !cur.cfg.ctrl[`WTS_CTRL_DEVEN] |=> !cur.dev;
   endproperty
   a_devOff: assert property (p_devOff) else $error("Deviation while disabled");

   property p_devBand;
      $fell(cur.dev) && cur.st != WTS_STOP && cur.cfg.ctrl[`WTS_CTRL_DEVEN]
         |-> $past(devProd <= clrThr);
   endproperty
   a_devBand: assert property (p_devBand) else $error("Deviation cleared inside band");

   property p_haltEnd;
      $past(cur.st) == WTS_HALT && $past(cur.haltLeft) == 20'h00000 && $past(tickHit)
         |-> motorSpeedRef == 16'h0000;
   endproperty
   a_haltEnd: assert property (p_haltEnd) else $error("Motor not stopped after halt");

   property p_hold;
      cur.st == WTS_HALT |-> tensionHold && pidOut == (cur.brk ? 16'h0000 : $past(pidIn));
   endproperty
   a_hold: assert property (p_hold) else $error("Tension not held in halt");

   property p_noSplice;
      inchOn |=> finalLineCmd == $past(lineCmd);
   endproperty
   a_noSplice: assert property (p_noSplice) else $error("Splice boost while inching");

   property p_ramp;
      inchOn && cur.cfg.ctrl[`WTS_CTRL_RAMPSEL] |=> accelTime == $past(cur.cfg.inchAcc);
   endproperty
   a_ramp: assert property (p_ramp) else $error("Inching ramp not applied");

endmodule
`default_nettype wire

/* wts_line_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Line controller model: drives the digital inputs of the drive
module wts_line_ctrl (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic nrst,
   // Requests from the sequence
   input  wire logic wantRun,
   input  wire logic wantHalt,
   input  wire logic wantInch,
   input  wire logic wantSplice,
   // Digital inputs of the drive
   output var logic  runPin,
   output var logic  haltPin,
   output var logic  inchPin,
   output var logic  inhibitPin
);
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         runPin     <= 1'b0;
         haltPin    <= 1'b0;
         inchPin    <= 1'b0;
         inhibitPin <= 1'b0;
      end
      else
      begin
         runPin     <= wantRun;
         haltPin    <= wantHalt;
         inchPin    <= wantInch;
         // Inhibit follows the splice request; the drive uses it for the splicing boost and the status register, not the PID
         inhibitPin <= wantSplice;
      end
   end
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic        mclk, nrst, wantRun, wantHalt, wantInch, wantSplice, regWr, regRd;
   wire  logic  runPin, haltPin, inchPin, inhibitPin;
   logic [15:0] tensionFb, lineCmd, lineSpeed, pidIn, speedRefIn, baseAccel, baseDecel;
   logic [15:0] regWdata, regRdata, pidOut, finalLineCmd, motorSpeedRef, accelTime, decelTime;
   logic [7:0]  regAddr;
   logic        diamHold, tensionHold, auxContact, ocContact, irq;
   int          mismatches, compares, i;
   logic [7:0]  resetAddr [6] = '{8'h00, 8'h04, 8'h1c, 8'h20, 8'h28, 8'h3c};
   logic [15:0] resetVal [6] = '{16'h0004, 16'h000a, 16'h01f4, 16'h01f4, 16'h0708, 16'h0000};

   wts_line_ctrl i_wts_line_ctrl (.mclk(mclk), .nrst(nrst), .wantRun(wantRun),
      .wantHalt(wantHalt), .wantInch(wantInch), .wantSplice(wantSplice), .runPin(runPin),
      .haltPin(haltPin), .inchPin(inchPin), .inhibitPin(inhibitPin));
   // Short tick keeps a tenth of a second at 400 cycles
   wts_supervisor #(.TICK_CYCLES(4)) i_wts_supervisor (.mclk(mclk), .nrst(nrst),
      .runPin(runPin), .haltPin(haltPin), .inchPin(inchPin), .inhibitPin(inhibitPin),
      .tensionFb(tensionFb), .lineCmd(lineCmd), .lineSpeed(lineSpeed), .pidIn(pidIn),
      .speedRefIn(speedRefIn), .baseAccel(baseAccel), .baseDecel(baseDecel),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .pidOut(pidOut), .finalLineCmd(finalLineCmd),
      .motorSpeedRef(motorSpeedRef), .accelTime(accelTime), .decelTime(decelTime),
      .diamHold(diamHold), .tensionHold(tensionHold), .auxContact(auxContact),
      .ocContact(ocContact), .irq(irq));

   // ==========================================================
   // Checking and bus tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // A wait that used up its bound ends the run at once
   task automatic guard(input int n);
      if (i >= n)
      begin
         mismatches++;
         $display("BAD %0t wait ran out", $time);
         end_of_test();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      regWr    <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge mclk);
      regWr    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge mclk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd   <= 1'b0;
      #1 chk(regRdata, exp);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // ==========================================================
   // Clock, stimulus and verdict
   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   initial
   begin
      {nrst, wantRun, wantHalt, wantInch, wantSplice, regWr, regRd} = '0;
      {regAddr, regWdata} = '0;
      tensionFb = 16'h03e8;
      lineCmd = 16'h03e8;
      lineSpeed = 16'h03e8;
      pidIn = 16'h1234;
      speedRefIn = 16'h03e8;
      baseAccel = 16'h0111;
      baseDecel = 16'h0222;
      mismatches = 0;
      compares = 0;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      for (i = 0; i < 6; i++) rd(resetAddr[i], resetVal[i]);
      // Break: enable, blank 0.3 s, confirm 0.1 s, level 50 %, both contacts on break
      wr(8'h00, 16'h0005);
      wr(8'h04, 16'h0003);
      wr(8'h08, 16'h0001);
      wr(8'h0c, 16'h01f4);
      wr(8'h2c, 16'h0005);
      wr(8'h38, 16'h0001);
      wantRun <= 1'b1;
      cyc(200);
      tensionFb <= 16'h0064;
      // Late in blanking, long after an unblanked break would have shown
      cyc(900);
      chk(auxContact, 1'b0);
      chk(ocContact, 1'b0);
      for (i = 0; i < 1500 && auxContact !== 1'b1; i++) cyc(1);
      guard(1500);
      cyc(300);
      chk(i > 300, 1'b1);
      chk(pidOut, 16'h0000);
      chk(auxContact, 1'b1);
      chk(ocContact, 1'b1);
      chk(irq, 1'b1);
      wr(8'h38, 16'h0000);
      cyc(1);
      chk(irq, 1'b0);
      tensionFb <= 16'h03e8;
      cyc(20);
      chk(auxContact, 1'b0);
      chk(ocContact, 1'b0);
      chk(pidOut, 16'h1234);
      // Deviation, level 10 %, hysteresis down to 8 %
      wr(8'h00, 16'h0006);
      wr(8'h10, 16'h0064);
      wr(8'h2c, 16'h0002);
      lineSpeed <= 16'h0352;
      cyc(20);
      chk(auxContact, 1'b1);
      lineSpeed <= 16'h038e;
      cyc(20);
      chk(auxContact, 1'b1);
      lineSpeed <= 16'h03a2;
      cyc(20);
      chk(auxContact, 1'b0);
      lineSpeed <= 16'h0352;
      wr(8'h00, 16'h0004);
      cyc(20);
      chk(auxContact, 1'b0);
      // Inching with splicing requested: 10 % of 1800 rpm, boost 10 %
      wr(8'h24, 16'h0064);
      wantSplice <= 1'b1;
      wantInch <= 1'b1;
      cyc(20);
      chk(motorSpeedRef, 16'h00b4);
      chk(diamHold, 1'b1);
      chk(accelTime, 16'h01f4);
      chk(decelTime, 16'h01f4);
      chk(finalLineCmd, 16'h03e8);
      wr(8'h00, 16'h0000);
      cyc(2);
      chk(accelTime, 16'h0111);
      chk(decelTime, 16'h0222);
      wantInch <= 1'b0;
      cyc(20);
      chk(finalLineCmd, 16'h044c);
      chk(diamHold, 1'b0);
      // Fixed-time halt of 0.1 s from 1000 rpm
      wantSplice <= 1'b0;
      wr(8'h14, 16'h0001);
      wr(8'h2c, 16'h0003);
      wr(8'h34, 16'h0007);
      wr(8'h38, 16'h0004);
      wantHalt <= 1'b1;
      cyc(200);
      chk(tensionHold, 1'b1);
      chk(auxContact, 1'b1);
      for (i = 0; i < 400 && motorSpeedRef !== 16'h0000; i++) cyc(1);
      guard(400);
      cyc(20);
      chk(motorSpeedRef, 16'h0000);
      chk(tensionHold, 1'b1);
      chk(irq, 1'b1);
      rd(8'h34, 16'h0004);
      wr(8'h34, 16'h0004);
      cyc(1);
      chk(irq, 1'b0);
      wantRun <= 1'b0;
      wantHalt <= 1'b0;
      cyc(10);
      chk(auxContact, 1'b0);
      rd(8'h30, 16'h0001);
      end_of_test();
   end
endmodule
`default_nettype wire
